//--- ipes_regs.sv
// The register offsets and the AHB-Lite interface to the registers were chosen for this implementation.
`timescale 1ns/10ps
// Function
// - Each priority register holds two 3-bit levels at bits 6..4 and 2..0.
// - Level code is plain binary, 000 lowest level 0, 111 highest level 7.
// - Priority fields serve maskable sources only; NMI has no programmable field.
// - Priority register bits 7 and 3 always read zero.
// - Every priority field resets to level 7.
// - Enable register is 8 bits; bits 0 to 5 enable pins 0 to 5.
// - A pin request passes only while enabled; enables reset to zero.
// - High sense register: bits 11..10 pin 5, bits 9..8 pin 4.
// - Sense code 00 raises a request while the pin is low; reset code.
// - Sense code 01 raises a request on each falling edge.
// - Code 10 requests on rising edges, code 11 on both edges.
// - Low sense register holds pins 3..0 at bits 7..6, 5..4, 3..2, 1..0.
// - Flag sets on the sense condition; cleared by read-while-1 then writing 0.
module ipes_regs #(
   parameter int NUM_PRIO = 12,   // Priority registers
   parameter int NUM_PINS = 6     // External request pins
) (
   input  wire logic                    hclk,            // System clock
   input  wire logic                    hresetn,         // Async reset, active low
   input  wire logic                    hsel,            // AHB slave select
   input  wire logic [31:0]             haddr,           // AHB byte address
   input  wire logic [1:0]              htrans,          // AHB transfer type
   input  wire logic                    hwrite,          // AHB write
   input  wire logic [2:0]              hsize,           // AHB size, word only
   input  wire logic                    hready,          // AHB bus ready
   input  wire logic [31:0]             hwdata,          // AHB write data
   output logic [31:0]                  hrdata,          // AHB read data
   output logic                         hreadyout,       // AHB slave ready
   output logic                         hresp,           // AHB response, OKAY
   input  wire logic [NUM_PINS-1:0]     ext_request_pin, // Request pins, asynchronous
   output logic [NUM_PINS-1:0]          pin_request,     // Enabled pending requests
   output logic [NUM_PRIO*6-1:0]        prio_levels      // {upper,lower} level per register
);

   // Elaboration checks: register map has room for 12 priority words and 6 pins
   if (NUM_PRIO < 1 || NUM_PRIO > 12) begin : g_chk_prio
      $error("NUM_PRIO must be 1 to 12");
   end
   if (NUM_PINS < 1 || NUM_PINS > 6) begin : g_chk_pins
      $error("NUM_PINS must be 1 to 6");
   end

   ipes_pkg::ipes_req_t    req;
   logic [15:0]            rd_data;
   logic [5:0]             prio_r [NUM_PRIO];
   logic [NUM_PINS-1:0]    enable_r;
   ipes_pkg::ipes_sense_t  sense_r [NUM_PINS];
   logic [NUM_PINS-1:0]    flag_r;
   logic [NUM_PINS-1:0]    flag_nxt;
   logic [NUM_PINS-1:0]    armed_r;
   logic [NUM_PINS-1:0]    armed_nxt;
   logic [NUM_PINS-1:0]    hit;
   logic [NUM_PINS-1:0]    clr;

   // Word index compare, qualified by the mapped window
   function automatic logic idx_is(input ipes_pkg::ipes_req_t r, input logic [3:0] idx);
      idx_is = r.mapped && (r.idx == idx);
   endfunction : idx_is

   // Priority word layout with reserved bits forced low
   function automatic logic [7:0] prio_word(input logic [5:0] f);
      prio_word = {1'b0, f[5:3], 1'b0, f[2:0]};
   endfunction : prio_word

   // Bus front end
   ipes_ahb_front u_front (
      .hclk      (hclk),
      .hresetn   (hresetn),
      .hsel      (hsel),
      .haddr     (haddr),
      .htrans    (htrans),
      .hwrite    (hwrite),
      .hsize     (hsize),
      .hready    (hready),
      .rd_data   (rd_data),
      .hrdata    (hrdata),
      .hreadyout (hreadyout),
      .hresp     (hresp),
      .req       (req)
   );

   // One sense detector per pin
   for (genvar p = 0; p < NUM_PINS; p++) begin : g_pin
      ipes_pin_sense u_sense (
         .hclk    (hclk),
         .hresetn (hresetn),
         .pin_in  (ext_request_pin[p]),
         .mode    (sense_r[p]),
         .hit     (hit[p])
      );
   end

   // Decoded write strobes, plus the status read strobe
   wire wr_enable = req.wr && idx_is(req, ipes_pkg::IDX_ENABLE);
   wire wr_sense_h = req.wr && idx_is(req, ipes_pkg::IDX_SENSE_HIGH);
   wire wr_sense_l = req.wr && idx_is(req, ipes_pkg::IDX_SENSE_LOW);
   wire wr_status = req.wr && idx_is(req, ipes_pkg::IDX_STATUS);
   wire rd_status = req.rd && idx_is(req, ipes_pkg::IDX_STATUS);
   wire wr_prio = req.wr && req.mapped && (req.idx < 4'(NUM_PRIO));

   // Priority registers; levels are plain binary, 3'h7 the highest
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         for (int i = 0; i < NUM_PRIO; i++) begin
            prio_r[i] <= {ipes_pkg::PRIO_RESET, ipes_pkg::PRIO_RESET};
         end
      end else if (wr_prio) begin
         prio_r[req.idx] <= {hwdata[ipes_pkg::UPPER_LSB +: ipes_pkg::LEVEL_W],
                             hwdata[ipes_pkg::LOWER_LSB +: ipes_pkg::LEVEL_W]};
      end
   end

   // Levels leave straight from the flops; no field here belongs to the non-maskable source
   for (genvar i = 0; i < NUM_PRIO; i++) begin : g_lvl
      assign prio_levels[i*6 +: 6] = prio_r[i];
   end

   // Enable register; bits 7..6 are not stored, software keeps them zero
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         enable_r <= ipes_pkg::ENABLE_RESET[NUM_PINS-1:0];
      end else if (wr_enable) begin
         enable_r <= hwdata[NUM_PINS-1:0];
      end
   end

   // Sense fields: pins from 4 up sit in the high register, the rest in the low one
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         for (int p = 0; p < NUM_PINS; p++) begin
            sense_r[p] <= ipes_pkg::SENSE_RESET;
         end
      end else begin
         for (int p = 0; p < NUM_PINS; p++) begin
            if (p >= ipes_pkg::SENSE_HIGH_PIN && wr_sense_h) begin
               sense_r[p] <= ipes_pkg::ipes_sense_t'(hwdata[p*2 +: 2]);
            end else if (p < ipes_pkg::SENSE_HIGH_PIN && wr_sense_l) begin
               sense_r[p] <= ipes_pkg::ipes_sense_t'(hwdata[p*2 +: 2]);
            end
         end
      end
   end

   // Flag clear needs a prior read that saw the bit at 1, then a 0 written to it.
   // A new hit in the clearing cycle wins, so no event is lost.
   assign clr       = wr_status ? (armed_r & ~hwdata[NUM_PINS-1:0]) : '0;
   assign flag_nxt  = hit | (flag_r & ~clr);
   assign armed_nxt = wr_status ? '0 : (rd_status ? (armed_r | flag_r) : armed_r);

   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         flag_r      <= ipes_pkg::FLAG_RESET[NUM_PINS-1:0];
         armed_r     <= '0;
         pin_request <= '0;
      end else begin
         flag_r      <= flag_nxt;
         armed_r     <= armed_nxt;
         pin_request <= flag_r & enable_r;
      end
   end

   // Read mux; unmapped words and unused bits read zero
   logic [15:0] sense_h_word;
   logic [15:0] sense_l_word;
   always_comb begin
      sense_h_word = 16'h0000;
      sense_l_word = 16'h0000;
      for (int p = 0; p < NUM_PINS; p++) begin
         if (p >= ipes_pkg::SENSE_HIGH_PIN) begin
            sense_h_word[p*2 +: 2] = sense_r[p];
         end else begin
            sense_l_word[p*2 +: 2] = sense_r[p];
         end
      end
   end

   always_comb begin
      rd_data = 16'h0000;
      if (req.mapped) begin
         if (req.idx < 4'(NUM_PRIO)) begin
            rd_data = {8'h00, prio_word(prio_r[req.idx])};
         end else begin
            case (req.idx)
               ipes_pkg::IDX_ENABLE:     rd_data = 16'(enable_r);
               ipes_pkg::IDX_SENSE_HIGH: rd_data = sense_h_word;
               ipes_pkg::IDX_SENSE_LOW:  rd_data = sense_l_word;
               ipes_pkg::IDX_STATUS:     rd_data = 16'(flag_r);
               default:                  rd_data = 16'h0000;
            endcase
         end
      end
   end

   // Helper for the reset check
   logic first_r;
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         first_r <= 1'b1;
      end else begin
         first_r <= 1'b0;
      end
   end

   default clocking cb @(posedge hclk); endclocking
   default disable iff (!hresetn);

   property p_prio_reset;
      first_r |-> (prio_r[0] == 6'h3f) && (prio_r[NUM_PRIO-1] == 6'h3f) && (enable_r == '0);
   endproperty
   a_prio_reset: assert property (p_prio_reset) else $error("reset values wrong");

   property p_prio_write;
      (wr_prio && req.idx == 4'h0) |=> prio_r[0] == {$past(hwdata[6:4]), $past(hwdata[2:0])};
   endproperty
   a_prio_write: assert property (p_prio_write) else $error("priority fields misplaced");

   property p_prio_rsv;
      (req.rd && req.mapped && req.idx < 4'(NUM_PRIO)) |=> hrdata[7] == 1'b0 && hrdata[3] == 1'b0;
   endproperty
   a_prio_rsv: assert property (p_prio_rsv) else $error("reserved priority bit read as one");

   property p_prio_level;
      (req.rd && req.mapped && req.idx == 4'h0) |=> hrdata[2:0] == $past(prio_r[0][2:0]);
   endproperty
   a_prio_level: assert property (p_prio_level) else $error("priority level read back wrong");

   property p_gate;
      ##1 pin_request == $past(flag_r & enable_r);
   endproperty
   a_gate: assert property (p_gate) else $error("request passed while disabled");

   property p_sense_high;
      wr_sense_h |=> sense_r[NUM_PINS-1] == $past(hwdata[(NUM_PINS-1)*2 +: 2]);
   endproperty
   a_sense_high: assert property (p_sense_high) else $error("high sense field misplaced");

   property p_sense_low;
      wr_sense_l |=> sense_r[0] == $past(hwdata[1:0]);
   endproperty
   a_sense_low: assert property (p_sense_low) else $error("low sense field misplaced");

   property p_flag_set;
      hit[0] |=> flag_r[0] ##1 (flag_r[0] || $past(clr[0]));
   endproperty
   a_flag_set: assert property (p_flag_set) else $error("flag not set by sense hit");

   property p_flag_hold;
      (flag_r[0] && !(wr_status && armed_r[0] && !hwdata[0])) |=> flag_r[0];
   endproperty
   a_flag_hold: assert property (p_flag_hold) else $error("flag cleared without read then zero");

   property p_level_low;
      (sense_r[0] == ipes_pkg::SENSE_LEVEL_LOW && !g_pin[0].u_sense.sync2_r) |=> flag_r[0];
   endproperty
   a_level_low: assert property (p_level_low) else $error("low level not flagged");

   // A hit landing on the clearing write must survive, or an event is lost
   property p_set_wins;
      (hit[0] && clr[0]) |=> flag_r[0];
   endproperty
   a_set_wins: assert property (p_set_wins) else $error("clear beat a new hit");

   property p_enable_write;
      wr_enable |=> enable_r == $past(hwdata[NUM_PINS-1:0]);
   endproperty
   a_enable_write: assert property (p_enable_write) else $error("enable write lost");

   c_clear: cover property (rd_status && flag_r[0] ##[1:20] wr_status && !hwdata[0]);
   c_request: cover property (enable_r[0] && hit[0] ##2 pin_request[0]);
   c_both: cover property (sense_r[0] == ipes_pkg::SENSE_BOTH && hit[0]);
   c_prio_write: cover property (wr_prio ##1 req.rd);

endmodule : ipes_regs

//--- ipes_pkg.sv
package ipes_pkg;

   // Register word indices; the byte address is four times the index
   localparam logic [3:0] IDX_PRIO_FIRST = 4'h0;   // priority_set_a .. _o take indices 0 to 11
   localparam logic [3:0] IDX_ENABLE     = 4'hc;   // pin_request_enable
   localparam logic [3:0] IDX_SENSE_HIGH = 4'hd;   // pin_sense_select_high
   localparam logic [3:0] IDX_SENSE_LOW  = 4'he;   // pin_sense_select_low
   localparam logic [3:0] IDX_STATUS     = 4'hf;   // pin_request_flag bits

   // Address decode: word index bits, and the bits that must be zero for a mapped access
   localparam int IDX_LSB  = 2;
   localparam int IDX_MSB  = 5;
   localparam int MAP_LSB  = 6;

   // Priority register field layout
   localparam int UPPER_LSB = 4;                   // upper_level_bit2..0 at 6..4
   localparam int LOWER_LSB = 0;                   // lower_level_bit2..0 at 2..0
   localparam int LEVEL_W   = 3;
   localparam logic [2:0] PRIO_RESET = 3'h7;

   // Sense field layout
   localparam int SENSE_W        = 2;
   localparam int SENSE_HIGH_LSB = 8;              // pin 4 at 9..8, pin 5 at 11..10
   localparam int SENSE_HIGH_PIN = 4;              // first pin held in the high register
   localparam logic [5:0] ENABLE_RESET = 6'h00;
   localparam logic [5:0] FLAG_RESET   = 6'h00;

   // Sensing modes
   typedef enum logic [1:0] {
      SENSE_LEVEL_LOW = 2'b00,
      SENSE_FALL      = 2'b01,
      SENSE_RISE      = 2'b10,
      SENSE_BOTH      = 2'b11
   } ipes_sense_t;

   localparam ipes_sense_t SENSE_RESET = SENSE_LEVEL_LOW;

   // Bus front-end states
   typedef enum logic [1:0] {
      BUS_IDLE  = 2'b00,
      BUS_WRITE = 2'b01,
      BUS_READ  = 2'b10
   } ipes_bus_st_t;

   // Register access request, valid for one cycle
   typedef struct packed {
      logic       wr;
      logic       rd;
      logic       mapped;
      logic [3:0] idx;
   } ipes_req_t;

endpackage : ipes_pkg

//--- ipes_pin_sense.sv
`timescale 1ns/10ps
module ipes_pin_sense (
   input  wire logic               hclk,      // System clock
   input  wire logic               hresetn,   // Async reset, active low
   input  wire logic               pin_in,    // Raw request pin, off-domain
   input  wire ipes_pkg::ipes_sense_t mode,   // Selected sensing mode
   output logic                    hit        // Sense condition seen this cycle
);

   logic sync1_r;
   logic sync2_r;
   logic prev_r;

   // Two-flop synchroniser, then one stage of history; idle pins rest high
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         sync1_r <= 1'b1;
         sync2_r <= 1'b1;
         prev_r  <= 1'b1;
      end else begin
         sync1_r <= pin_in;
         sync2_r <= sync1_r;
         prev_r  <= sync2_r;
      end
   end

   // Edges come from successive synchronised samples, never from the raw pin
   always_comb begin
      case (mode)
         ipes_pkg::SENSE_LEVEL_LOW: hit = ~sync2_r;
         ipes_pkg::SENSE_FALL:      hit = prev_r & ~sync2_r;
         ipes_pkg::SENSE_RISE:      hit = ~prev_r & sync2_r;
         ipes_pkg::SENSE_BOTH:      hit = prev_r ^ sync2_r;
         default:                   hit = 1'b0;
      endcase
   end

   property p_fall_hit;
      @(posedge hclk) disable iff (!hresetn)
      (mode == ipes_pkg::SENSE_FALL && $fell(sync2_r)) |-> hit;
   endproperty
   a_fall_hit: assert property (p_fall_hit) else $error("falling edge not reported");

   property p_sync_delay;
      @(posedge hclk) disable iff (!hresetn)
      $rose(sync1_r) |=> sync2_r;
   endproperty
   a_sync_delay: assert property (p_sync_delay) else $error("synchroniser stage lost");

endmodule : ipes_pin_sense

//--- ipes_ahb_front.sv
`timescale 1ns/10ps
module ipes_ahb_front (
   input  wire logic                 hclk,       // System clock
   input  wire logic                 hresetn,    // Async reset, active low
   input  wire logic                 hsel,       // Slave select
   input  wire logic [31:0]          haddr,      // Byte address
   input  wire logic [1:0]           htrans,     // Transfer type
   input  wire logic                 hwrite,     // Write when high
   input  wire logic [2:0]           hsize,      // Word only, not checked
   input  wire logic                 hready,     // Bus ready
   input  wire logic [15:0]          rd_data,    // Read word from register file
   output logic [31:0]               hrdata,     // Read data
   output logic                      hreadyout,  // Slave ready
   output logic                      hresp,      // Always OKAY
   output ipes_pkg::ipes_req_t       req         // Register access request
);

   ipes_pkg::ipes_bus_st_t st_r;
   ipes_pkg::ipes_bus_st_t st_nxt;
   logic [3:0]             idx_r;
   logic                   mapped_r;
   logic                   take;

   // Address phase is taken on any NONSEQ or SEQ while the bus is ready
   assign take   = hsel & htrans[1] & hready;
   assign st_nxt = take ? (hwrite ? ipes_pkg::BUS_WRITE : ipes_pkg::BUS_READ) : ipes_pkg::BUS_IDLE;

   // Request lives in the data-phase cycle; reads get one wait state so a write just before is seen
   assign req.wr     = (st_r == ipes_pkg::BUS_WRITE);
   assign req.rd     = (st_r == ipes_pkg::BUS_READ);
   assign req.mapped = mapped_r;
   assign req.idx    = idx_r;

   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         st_r      <= ipes_pkg::BUS_IDLE;
         idx_r     <= 4'h0;
         mapped_r  <= 1'b0;
         hreadyout <= 1'b1;
         hrdata    <= 32'h0000_0000;
         hresp     <= 1'b0;
      end else begin
         st_r      <= st_nxt;
         hreadyout <= ~(take & ~hwrite);
         hresp     <= 1'b0;
         if (take) begin
            idx_r    <= haddr[ipes_pkg::IDX_MSB:ipes_pkg::IDX_LSB];
            mapped_r <= (haddr[31:ipes_pkg::MAP_LSB] == 26'h000_0000);
         end
         if (st_r == ipes_pkg::BUS_READ) begin
            hrdata <= {16'h0000, rd_data};   // Upper half reads zero
         end
      end
   end

   property p_read_wait;
      @(posedge hclk) disable iff (!hresetn)
      (take && !hwrite) |=> !hreadyout ##1 hreadyout;
   endproperty
   a_read_wait: assert property (p_read_wait) else $error("read wait state wrong");

endmodule : ipes_ahb_front

//--- ipes_pin_model.sv
`timescale 1ns/10ps
module ipes_pin_model (
   input  wire logic       hclk,            // System clock
   input  wire logic       hresetn,         // Async reset, active low
   input  wire logic [5:0] level_cmd,       // Level asked for by the bench
   output logic [5:0]      ext_request_pin  // Request pins seen by the device
);
   // Board pull-ups keep the pins high in reset, so the device never sees a false low level
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         ext_request_pin <= 6'h3f;
      end else begin
         ext_request_pin <= level_cmd;
      end
   end
endmodule : ipes_pin_model

//--- irq_priority_enable_sense_regs_tb_top.sv
`timescale 1ns/10ps
module irq_priority_enable_sense_regs_tb_top;
   localparam logic [31:0] A_EN = {26'h0, ipes_pkg::IDX_ENABLE, 2'b00};
   localparam logic [31:0] A_HI = {26'h0, ipes_pkg::IDX_SENSE_HIGH, 2'b00};
   localparam logic [31:0] A_LO = {26'h0, ipes_pkg::IDX_SENSE_LOW, 2'b00};
   localparam logic [31:0] A_ST = {26'h0, ipes_pkg::IDX_STATUS, 2'b00};
   logic        hclk;
   logic        hresetn;
   logic        hsel;
   logic [31:0] haddr;
   logic [1:0]  htrans;
   logic        hwrite;
   logic [31:0] hwdata;
   logic [31:0] hrdata;
   logic        hreadyout;
   logic        hresp;
   logic [5:0]  level_cmd;
   logic [5:0]  ext_request_pin;
   logic [5:0]  pin_request;
   logic [71:0] prio_levels;
   logic [31:0] seed;
   int          fail_count;
   int          compares;

   ipes_regs #(.NUM_PRIO(12), .NUM_PINS(6)) u_ipes_regs (
      .hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr), .htrans(htrans),
      .hwrite(hwrite), .hsize(3'h2), .hready(hreadyout), .hwdata(hwdata), .hrdata(hrdata),
      .hreadyout(hreadyout), .hresp(hresp), .ext_request_pin(ext_request_pin),
      .pin_request(pin_request), .prio_levels(prio_levels));

   ipes_pin_model u_ipes_pin_model (
      .hclk(hclk), .hresetn(hresetn), .level_cmd(level_cmd), .ext_request_pin(ext_request_pin));

   // 125 MHz system clock
   initial begin
      hclk = 1'b0;
      forever #4 hclk = ~hclk;
   end

   // Repeatable pseudo-random source
   function automatic logic [31:0] xorshift(input logic [31:0] s);
      logic [31:0] x;
      x = s ^ (s << 13);
      x = x ^ (x >> 17);
      x = x ^ (x << 5);
      return x;
   endfunction : xorshift

   // Flags expected after a falling or a rising edge on every pin
   function automatic logic [5:0] flags_exp(input logic [11:0] modes, input logic rising);
      logic [5:0] f;
      for (int p = 0; p < 6; p++) begin
         f[p] = rising ? (modes[2*p+1] || modes[2*p +: 2] == 2'b00) : (modes[2*p +: 2] != 2'b10);
      end
      return f;
   endfunction : flags_exp

   task automatic report_and_stop();
      $display("Counts: %0d compares, %0d mismatches", compares, fail_count);
      if (fail_count == 0 && compares > 0) begin
         $display("Simulation passed");
      end else begin
         $display("Simulation failed");
      end
      $finish;
   endtask : report_and_stop

   task automatic chk_reg(input string name, input logic [31:0] exp, input logic [31:0] got);
      compares++;
      if (got !== exp) begin
         fail_count++;
         $display("CHECK FAILED %s: expected %h, seen %h", name, exp, got);
      end
   endtask : chk_reg

   task automatic chk_out(input string name, input logic [7:0] exp, input logic [7:0] got);
      compares++;
      if (got !== exp) begin
         fail_count++;
         $display("CHECK FAILED %s: expected %h, seen %h", name, exp, got);
      end
   endtask : chk_out

   // Waits for hready high at a rising edge; a hung slave ends the run
   task automatic wait_ready();
      int n;
      n = 0;
      @(posedge hclk);
      while (hreadyout !== 1'b1) begin
         n++;
         if (n > 20) begin
            fail_count++;
            $display("CHECK FAILED hready wait: expected 1, seen %b", hreadyout);
            report_and_stop();
         end
         @(posedge hclk);
      end
   endtask : wait_ready

   // One single-word transfer; entered and left at a rising edge
   task automatic xfer(input logic wr, input logic [31:0] addr, input logic [31:0] wdata,
                       output logic [31:0] rdata);
      hsel   <= 1'b1;
      htrans <= 2'b10;
      haddr  <= addr;
      hwrite <= wr;
      wait_ready();
      hsel   <= 1'b0;
      htrans <= 2'b00;
      hwdata <= wdata;
      wait_ready();
      rdata = hrdata;
      chk_out("hresp", 8'h00, {7'h0, hresp});
   endtask : xfer

   task automatic wr(input logic [31:0] addr, input logic [31:0] data);
      logic [31:0] r;
      xfer(1'b1, addr, data, r);
   endtask : wr

   task automatic rd_chk(input string name, input logic [31:0] addr, input logic [31:0] exp);
      logic [31:0] r;
      xfer(1'b0, addr, 32'h0, r);
      chk_reg(name, exp, r);
   endtask : rd_chk

   // Read arms the set flags, the following write of zero clears them
   task automatic clear_flags();
      logic [31:0] r;
      xfer(1'b0, A_ST, 32'h0, r);
      wr(A_ST, 32'h0);
   endtask : clear_flags

   initial begin
      logic [31:0] d;
      logic [11:0] modes;
      logic [5:0]  en;
      logic [5:0]  f;
      seed = 32'h00000061;
      fail_count = 0;
      compares = 0;
      hresetn = 1'b0;
      hsel = 1'b0;
      haddr = 32'h0;
      htrans = 2'b00;
      hwrite = 1'b0;
      hwdata = 32'h0;
      level_cmd = 6'h3f;
      repeat (4) @(posedge hclk);
      hresetn <= 1'b1;
      // Reset values of every register
      for (int i = 0; i < 12; i++) begin
         rd_chk("priority reset", 32'(i * 4), 32'h77);
         chk_out("level field reset", 8'h3f, {2'b00, prio_levels[i*6 +: 6]});
      end
      rd_chk("enable reset", A_EN, 32'h0);
      rd_chk("sense high reset", A_HI, 32'h0);
      rd_chk("sense low reset", A_LO, 32'h0);
      rd_chk("status reset", A_ST, 32'h0);
      $display("test reset_values done");
      // Priority fields with corner and random words; reserved bits must read zero
      for (int i = 0; i < 24; i++) begin
         seed = xorshift(seed);
         d = (i == 0) ? 32'hffffffff : (i == 1) ? 32'h00000088 : seed;
         wr(32'((i % 12) * 4), d);
         rd_chk("priority readback", 32'((i % 12) * 4), d & 32'h77);
         chk_out("level fields", {2'b00, d[6:4], d[2:0]}, {2'b00, prio_levels[(i%12)*6 +: 6]});
      end
      $display("test priority_fields done");
      // Enable register, then accesses outside the map
      wr(A_EN, 32'h0000003f);
      rd_chk("enable readback", A_EN, 32'h3f);
      wr(32'h00100030, 32'h0);
      rd_chk("enable after unmapped write", A_EN, 32'h3f);
      rd_chk("unmapped read", 32'h00000070, 32'h0);
      $display("test enable_and_unmapped done");
      // Sense modes: uniform codes first, then random per-pin codes; enables random in every pass
      for (int it = 0; it < 10; it++) begin
         seed = xorshift(seed);
         modes = (it < 4) ? {6{2'(it)}} : seed[11:0];
         en = seed[17:12];
         wr(A_LO, {24'h0, modes[7:0]});
         wr(A_HI, {20'h0, modes[11:8], 8'h00});
         rd_chk("sense high", A_HI, {20'h0, modes[11:8], 8'h00});
         rd_chk("sense low", A_LO, {24'h0, modes[7:0]});
         wr(A_EN, {26'h0, en});
         level_cmd <= 6'h00;
         repeat (6) @(posedge hclk);
         f = flags_exp(modes, 1'b0);
         chk_out("pin_request after fall", {2'b00, f & en}, {2'b00, pin_request});
         rd_chk("status after fall", A_ST, {26'h0, f});
         clear_flags();
         level_cmd <= 6'h3f;
         repeat (6) @(posedge hclk);
         f = flags_exp(modes, 1'b1);
         chk_out("pin_request after rise", {2'b00, f & en}, {2'b00, pin_request});
         rd_chk("status after rise", A_ST, {26'h0, f});
         clear_flags();
         rd_chk("status after clear", A_ST, 32'h0);
      end
      $display("test sense_modes done");
      // Reset in mid-run returns written registers to their reset values
      wr(32'h0, 32'h0);
      hresetn <= 1'b0;
      repeat (2) @(posedge hclk);
      hresetn <= 1'b1;
      rd_chk("priority after reset", 32'h0, 32'h77);
      chk_out("level field after reset", 8'h3f, {2'b00, prio_levels[5:0]});
      rd_chk("enable after reset", A_EN, 32'h0);
      rd_chk("sense low after reset", A_LO, 32'h0);
      rd_chk("status after reset", A_ST, 32'h0);
      $display("test mid_reset done");
      report_and_stop();
   end
endmodule : irq_priority_enable_sense_regs_tb_top
